// ---- core/gpio_cfg_pkg.sv ----
// Shared constants and types for the remote-capable pin configuration block.
// Assumes a single 100 MHz core clock and an Avalon-MM register master.
package gpio_cfg_pkg;

  // ------------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;

  // ------------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ------------------------------------------------------------------
  localparam logic [7:0] IDX_PIN3_CFG  = 8'h1f;
  localparam logic [7:0] IDX_PIN56_CFG = 8'h20;
  localparam logic [7:0] IDX_PIN78_CFG = 8'h21;
  localparam logic [7:0] IDX_PAD_LEVEL = 8'h24;
  localparam logic [7:0] IDX_PORT_CTRL = 8'h25;

  localparam logic [7:0] ADDR_PIN3_CFG  = {IDX_PIN3_CFG[5:0], 2'h0};
  localparam logic [7:0] ADDR_PIN56_CFG = {IDX_PIN56_CFG[5:0], 2'h0};
  localparam logic [7:0] ADDR_PIN78_CFG = {IDX_PIN78_CFG[5:0], 2'h0};
  localparam logic [7:0] ADDR_PAD_LEVEL = {IDX_PAD_LEVEL[5:0], 2'h0};
  localparam logic [7:0] ADDR_PORT_CTRL = {IDX_PORT_CTRL[5:0], 2'h0};

  // ------------------------------------------------------------------
  // Reset values and field positions
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_CFG       = 8'h00;
  localparam logic       RST_PORT_SEL  = 1'b0;
  localparam int         FLD_OUT_VAL   = 3;
  localparam int         FLD_REMOTE    = 2;
  localparam int         FLD_DIR       = 1;
  localparam int         FLD_EN        = 0;
  localparam int         NIB_LO        = 0;
  localparam int         NIB_HI        = 4;
  localparam int         PORT_SEL_BIT  = 0;

  // ------------------------------------------------------------------
  // Pad numbering on the PAD_* vectors
  // ------------------------------------------------------------------
  localparam int NUM_PADS = 6;
  localparam int PAD_PIN3 = 0;
  localparam int PAD_ALT3 = 1;
  localparam int PAD_PIN5 = 2;
  localparam int PAD_PIN6 = 3;
  localparam int PAD_PIN7 = 4;
  localparam int PAD_PIN8 = 5;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  // Encoding is {direction, enable}
  typedef enum logic [1:0] {
    MODE_FUNC_OUT = 2'h0,
    MODE_GPIO_OUT = 2'h1,
    MODE_TRISTATE = 2'h2,
    MODE_GPIO_IN  = 2'h3
  } pad_mode_t;

  typedef struct packed {
    logic      out_val;
    logic      remote_en;
    pad_mode_t mode;
  } pin_cfg_t;

  typedef struct packed {
    logic oe;
    logic val;
  } pad_drive_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK  = 2'h2
  } bus_state_t;

endpackage

// ---- core/pin_ctrl.sv ----
// Drive decision for one pad from its 4-bit configuration field.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module pin_ctrl
(
  // Configuration
  input  wire gpio_cfg_pkg::pin_cfg_t   cfg,
  input  wire logic                     routed,
  // Candidate values
  input  wire logic                     func_val,
  input  wire logic                     remote_val,
  // Result
  output gpio_cfg_pkg::pad_drive_t      drive
);

  always_comb
  begin
    drive = '0;
    // Pad not steered by this field: keep it off the wire
    if (!routed)
    begin
      drive = '0;
    end
    else if (cfg.remote_en)
    begin
      drive.oe  = 1'b1;
      drive.val = remote_val;
    end
    else
    begin
      unique case (cfg.mode)
        gpio_cfg_pkg::MODE_FUNC_OUT:
        begin
          drive.oe  = 1'b1;
          drive.val = func_val;
        end
        gpio_cfg_pkg::MODE_GPIO_OUT:
        begin
          drive.oe  = 1'b1;
          drive.val = cfg.out_val;
        end
        gpio_cfg_pkg::MODE_TRISTATE:
        begin
          drive = '0;
        end
        gpio_cfg_pkg::MODE_GPIO_IN:
        begin
          drive = '0;
        end
      endcase
    end
  end

endmodule

// ---- core/gpio_config_top.sv ----
// Register file and pad control for pins 3, 5, 6, 7, 8 and second-port pin 3.
// Assumes an Avalon-MM master with waitrequest and pad inputs synchronous to CLK.
`timescale 1ns/1ps
module gpio_config_top
(
  // Clock and reset
  input  wire logic                              CLK,
  input  wire logic                              SRST,
  // Avalon-MM slave
  input  wire logic [gpio_cfg_pkg::ADDR_W-1:0]   AVS_ADDRESS,
  input  wire logic                              AVS_READ,
  input  wire logic                              AVS_WRITE,
  input  wire logic [gpio_cfg_pkg::BE_W-1:0]     AVS_BYTEENABLE,
  input  wire logic [gpio_cfg_pkg::DATA_W-1:0]   AVS_WRITEDATA,
  output logic      [gpio_cfg_pkg::DATA_W-1:0]   AVS_READDATA,
  output logic                                   AVS_WAITREQUEST,
  // Second-port routing for the pin-3 field
  input  wire logic                              PORT_SEL,
  // Pad sources
  input  wire logic [gpio_cfg_pkg::NUM_PADS-1:0] PAD_FUNC,
  input  wire logic [gpio_cfg_pkg::NUM_PADS-1:0] PAD_REMOTE,
  input  wire logic [gpio_cfg_pkg::NUM_PADS-1:0] PAD_IN,
  // Pad drivers
  output logic      [gpio_cfg_pkg::NUM_PADS-1:0] PAD_OUT,
  output logic      [gpio_cfg_pkg::NUM_PADS-1:0] PAD_OE
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                          input logic [7:0] r3,
                                          input logic [7:0] r56,
                                          input logic [7:0] r78,
                                          input logic [5:0] lvl,
                                          input logic       psel);
    logic [7:0] d;
    d = 8'h00;
    unique case (addr)
      gpio_cfg_pkg::ADDR_PIN3_CFG:  d = r3;
      gpio_cfg_pkg::ADDR_PIN56_CFG: d = r56;
      gpio_cfg_pkg::ADDR_PIN78_CFG: d = r78;
      gpio_cfg_pkg::ADDR_PAD_LEVEL: d = {2'h0, lvl};
      gpio_cfg_pkg::ADDR_PORT_CTRL: d = {7'h00, psel};
      default:                      d = 8'h00;
    endcase
    return d;
  endfunction

  function automatic gpio_cfg_pkg::pin_cfg_t pad_field(input int idx,
                                                       input logic [7:0] r3,
                                                       input logic [7:0] r56,
                                                       input logic [7:0] r78);
    logic [3:0] n;
    n = 4'h0;
    unique case (idx)
      gpio_cfg_pkg::PAD_PIN3: n = r3[gpio_cfg_pkg::NIB_LO +: 4];
      gpio_cfg_pkg::PAD_ALT3: n = r3[gpio_cfg_pkg::NIB_LO +: 4];
      gpio_cfg_pkg::PAD_PIN5: n = r56[gpio_cfg_pkg::NIB_LO +: 4];
      gpio_cfg_pkg::PAD_PIN6: n = r56[gpio_cfg_pkg::NIB_HI +: 4];
      gpio_cfg_pkg::PAD_PIN7: n = r78[gpio_cfg_pkg::NIB_LO +: 4];
      default:                n = r78[gpio_cfg_pkg::NIB_HI +: 4];
    endcase
    return gpio_cfg_pkg::pin_cfg_t'(n);
  endfunction

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  gpio_cfg_pkg::bus_state_t state_r;
  gpio_cfg_pkg::bus_state_t state_nxt;
  logic                     wait_r;
  logic                     wait_nxt;
  logic [31:0]              rdata_r;
  logic [31:0]              rdata_nxt;
  logic [7:0]               pin3_cfg_r;
  logic [7:0]               pin3_cfg_nxt;
  logic [7:0]               pin56_cfg_r;
  logic [7:0]               pin56_cfg_nxt;
  logic [7:0]               pin78_cfg_r;
  logic [7:0]               pin78_cfg_nxt;
  logic                     port_sel_r;
  logic                     port_sel_nxt;
  logic [5:0]               level_r;
  logic                     commit;

  // One wait cycle, then a single acknowledge cycle
  assign commit = (state_r == gpio_cfg_pkg::BUS_ACK) && AVS_WRITE && AVS_BYTEENABLE[0];

  always_comb
  begin
    state_nxt     = state_r;
    wait_nxt      = wait_r;
    rdata_nxt     = rdata_r;
    pin3_cfg_nxt  = pin3_cfg_r;
    pin56_cfg_nxt = pin56_cfg_r;
    pin78_cfg_nxt = pin78_cfg_r;
    port_sel_nxt  = port_sel_r;
    unique case (state_r)
      gpio_cfg_pkg::BUS_IDLE:
      begin
        if (AVS_READ || AVS_WRITE)
        begin
          state_nxt = gpio_cfg_pkg::BUS_ACK;
          wait_nxt  = 1'b0;
          rdata_nxt = {24'h000000, read_mux(AVS_ADDRESS, pin3_cfg_r, pin56_cfg_r,
                                            pin78_cfg_r, level_r, port_sel_r)};
        end
      end
      gpio_cfg_pkg::BUS_ACK:
      begin
        state_nxt = gpio_cfg_pkg::BUS_IDLE;
        wait_nxt  = 1'b1;
        if (commit)
        begin
          unique case (AVS_ADDRESS)
            gpio_cfg_pkg::ADDR_PIN3_CFG:  pin3_cfg_nxt  = AVS_WRITEDATA[7:0];
            gpio_cfg_pkg::ADDR_PIN56_CFG: pin56_cfg_nxt = AVS_WRITEDATA[7:0];
            gpio_cfg_pkg::ADDR_PIN78_CFG: pin78_cfg_nxt = AVS_WRITEDATA[7:0];
            gpio_cfg_pkg::ADDR_PORT_CTRL:
              port_sel_nxt = AVS_WRITEDATA[gpio_cfg_pkg::PORT_SEL_BIT];
            default:                      port_sel_nxt = port_sel_r;
          endcase
        end
      end
      default:
      begin
        state_nxt = gpio_cfg_pkg::BUS_IDLE;
        wait_nxt  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      state_r     <= gpio_cfg_pkg::BUS_IDLE;
      wait_r      <= 1'b1;
      rdata_r     <= '0;
      pin3_cfg_r  <= gpio_cfg_pkg::RST_CFG;
      pin56_cfg_r <= gpio_cfg_pkg::RST_CFG;
      pin78_cfg_r <= gpio_cfg_pkg::RST_CFG;
      port_sel_r  <= gpio_cfg_pkg::RST_PORT_SEL;
    end
    else
    begin
      state_r     <= state_nxt;
      wait_r      <= wait_nxt;
      rdata_r     <= rdata_nxt;
      pin3_cfg_r  <= pin3_cfg_nxt;
      pin56_cfg_r <= pin56_cfg_nxt;
      pin78_cfg_r <= pin78_cfg_nxt;
      port_sel_r  <= port_sel_nxt;
    end
  end

  assign AVS_WAITREQUEST = wait_r;
  assign AVS_READDATA    = rdata_r;

  // ----------------------------------------------------------------
  // Pad control
  // ----------------------------------------------------------------
  // Strap and register bit both may steer the field to the second port
  logic                     sel_alt;
  gpio_cfg_pkg::pin_cfg_t   pad_cfg [gpio_cfg_pkg::NUM_PADS];
  logic [5:0]               pad_routed;
  gpio_cfg_pkg::pad_drive_t drv [gpio_cfg_pkg::NUM_PADS];
  logic [5:0]               out_nxt;
  logic [5:0]               oe_nxt;
  logic [5:0]               out_r;
  logic [5:0]               oe_r;

  assign sel_alt = port_sel_r | PORT_SEL;

  genvar gi;
  generate
    for (gi = 0; gi < gpio_cfg_pkg::NUM_PADS; gi++)
    begin : g_pad
      assign pad_cfg[gi] = pad_field(gi, pin3_cfg_r, pin56_cfg_r, pin78_cfg_r);
      assign pad_routed[gi] = (gi == gpio_cfg_pkg::PAD_PIN3) ? !sel_alt :
                              (gi == gpio_cfg_pkg::PAD_ALT3) ? sel_alt : 1'b1;
      pin_ctrl u_pin
      (
        .cfg        (pad_cfg[gi]),
        .routed     (pad_routed[gi]),
        .func_val   (PAD_FUNC[gi]),
        .remote_val (PAD_REMOTE[gi]),
        .drive      (drv[gi])
      );
      assign out_nxt[gi] = drv[gi].val;
      assign oe_nxt[gi]  = drv[gi].oe;
    end
  endgenerate

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      out_r   <= '0;
      oe_r    <= '0;
      level_r <= '0;
    end
    else
    begin
      out_r   <= out_nxt;
      oe_r    <= oe_nxt;
      level_r <= PAD_IN;
    end
  end

  assign PAD_OUT = out_r;
  assign PAD_OE  = oe_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_req_taken;
    (state_r == gpio_cfg_pkg::BUS_IDLE) && (AVS_READ || AVS_WRITE);
  endsequence

  sequence s_one_ack;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence

  property p_bus_ack;
    @(posedge CLK) disable iff (SRST)
    s_req_taken |=> s_one_ack;
  endproperty
  a_bus_ack: assert property (p_bus_ack)
    else $error("waitrequest did not pulse low for one cycle");

  sequence s_pin5_input_write;
    commit && (AVS_ADDRESS == gpio_cfg_pkg::ADDR_PIN56_CFG)
    && (AVS_WRITEDATA[3:0] == 4'h3);
  endsequence

  property p_write_to_pad;
    @(posedge CLK) disable iff (SRST)
    s_pin5_input_write |-> ##2 !PAD_OE[gpio_cfg_pkg::PAD_PIN5];
  endproperty
  a_write_to_pad: assert property (p_write_to_pad)
    else $error("pad did not follow a completed write in time");

  property p_nibble_hi;
    @(posedge CLK) disable iff (SRST)
    (commit && AVS_ADDRESS == gpio_cfg_pkg::ADDR_PIN78_CFG)
      |=> pad_cfg[gpio_cfg_pkg::PAD_PIN8] == $past(AVS_WRITEDATA[7:4]);
  endproperty
  a_nibble_hi: assert property (p_nibble_hi)
    else $error("upper nibble did not reach pin 8 field");

  property p_reserved_kept;
    @(posedge CLK) disable iff (SRST)
    (commit && AVS_ADDRESS == gpio_cfg_pkg::ADDR_PIN3_CFG)
      |=> pin3_cfg_r[7:4] == $past(AVS_WRITEDATA[7:4]);
  endproperty
  a_reserved_kept: assert property (p_reserved_kept)
    else $error("reserved nibble of pin 3 field not stored");

  property p_alt_route;
    @(posedge CLK) disable iff (SRST)
    sel_alt |=> !PAD_OE[gpio_cfg_pkg::PAD_PIN3];
  endproperty
  a_alt_route: assert property (p_alt_route)
    else $error("primary pin 3 driven while second port selected");

  generate
    for (gi = 0; gi < gpio_cfg_pkg::NUM_PADS; gi++)
    begin : g_chk
      property p_local_out;
        @(posedge CLK) disable iff (SRST)
        (pad_routed[gi] && !pad_cfg[gi].remote_en
          && pad_cfg[gi].mode == gpio_cfg_pkg::MODE_GPIO_OUT)
          |=> PAD_OE[gi] && (PAD_OUT[gi] == $past(pad_cfg[gi].out_val));
      endproperty
      a_local_out: assert property (p_local_out)
        else $error("local value not driven in GPIO output mode");

      property p_remote;
        @(posedge CLK) disable iff (SRST)
        (pad_routed[gi] && pad_cfg[gi].remote_en)
          |=> PAD_OE[gi] && (PAD_OUT[gi] == $past(PAD_REMOTE[gi]));
      endproperty
      a_remote: assert property (p_remote)
        else $error("remote value not forced onto pad");

      property p_func;
        @(posedge CLK) disable iff (SRST)
        (pad_routed[gi] && !pad_cfg[gi].remote_en
          && pad_cfg[gi].mode == gpio_cfg_pkg::MODE_FUNC_OUT)
          |=> PAD_OE[gi] && (PAD_OUT[gi] == $past(PAD_FUNC[gi]));
      endproperty
      a_func: assert property (p_func)
        else $error("remote value leaked into local functional mode");

      property p_released;
        @(posedge CLK) disable iff (SRST)
        (!pad_cfg[gi].remote_en && pad_cfg[gi].mode[gpio_cfg_pkg::FLD_DIR])
          |=> !PAD_OE[gi];
      endproperty
      a_released: assert property (p_released)
        else $error("pad driven in tri-state or input mode");

      property p_input_level;
        @(posedge CLK) disable iff (SRST)
        (pad_cfg[gi].mode == gpio_cfg_pkg::MODE_GPIO_IN && !pad_cfg[gi].remote_en)
          |=> (level_r[gi] == $past(PAD_IN[gi])) && !PAD_OE[gi];
      endproperty
      a_input_level: assert property (p_input_level)
        else $error("input mode pad not released or level not captured");
    end
  endgenerate

endmodule

// ---- bench/pad_link_model.sv ----
// Far-side model: pad loads and the link feeding remote pin values.
// Assumes the bench chooses the functional, link and external levels.
`timescale 1ns/1ps
module pad_link_model
(
  // Pad drivers from the block
  input  wire logic [5:0] PAD_OUT,
  input  wire logic [5:0] PAD_OE,
  // Levels chosen by the bench
  input  wire logic [5:0] func_pat,
  input  wire logic [5:0] link_pat,
  input  wire logic [5:0] ext_pat,
  // Pad sources to the block
  output logic      [5:0] PAD_FUNC,
  output logic      [5:0] PAD_REMOTE,
  output logic      [5:0] PAD_IN
);
  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  // External driver only wins where the block lets go of the pad
  assign PAD_IN     = (PAD_OE & PAD_OUT) | (~PAD_OE & ext_pat);
  assign PAD_FUNC   = func_pat;
  assign PAD_REMOTE = link_pat;
endmodule

// ---- bench/tb_top.sv ----
// Bench for the pin configuration block: register access and pad checks.
// Assumes one 100 MHz clock and a slave that answers by lowering waitrequest.
`timescale 1ns/1ps
module tb_top;
  logic        CLK = 1'b0;
  logic        SRST = 1'b1;
  logic [7:0]  AVS_ADDRESS = 8'h00;
  logic        AVS_READ = 1'b0;
  logic        AVS_WRITE = 1'b0;
  logic [3:0]  AVS_BYTEENABLE = 4'h0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic        PORT_SEL = 1'b0;
  logic [5:0]  PAD_FUNC, PAD_REMOTE, PAD_IN, PAD_OUT, PAD_OE;
  logic [5:0]  func_pat = 6'h15;
  logic [5:0]  link_pat = 6'h2a;
  logic [5:0]  ext_pat = 6'h00;
  logic [7:0]  c3 = 8'h00;
  logic [7:0]  c56 = 8'h00;
  logic [7:0]  c78 = 8'h00;
  logic        psel = 1'b0;
  int          err_count = 0;
  int          cmp_count = 0;

  always #5 CLK = ~CLK;

  gpio_config_top DUT (.CLK(CLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .PORT_SEL(PORT_SEL), .PAD_FUNC(PAD_FUNC),
    .PAD_REMOTE(PAD_REMOTE), .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE));

  pad_link_model partner (.PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE), .func_pat(func_pat),
    .link_pat(link_pat), .ext_pat(ext_pat), .PAD_FUNC(PAD_FUNC),
    .PAD_REMOTE(PAD_REMOTE), .PAD_IN(PAD_IN));

  // ----------------------------------------
  // Report helpers
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic fail(input string msg);
    err_count++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask

  // ----------------------------------------
  // Bus access
  // ----------------------------------------
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int   n;
    logic ok;
    @(posedge CLK);
    AVS_ADDRESS    <= a;
    AVS_WRITE      <= wr;
    AVS_READ       <= ~wr;
    AVS_WRITEDATA  <= {24'h0, d};
    AVS_BYTEENABLE <= be;
    n  = 0;
    ok = 1'b0;
    while (!ok && n < 20)
    begin
      @(posedge CLK);
      n++;
      ok = (AVS_WAITREQUEST === 1'b0);
    end
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ  <= 1'b0;
    if (!ok)
    begin
      fail("bus answer timed out");
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, 4'hf, q);
    cmp_count++;
    if (q !== {24'h0, e})
      fail($sformatf("read %h got %h want %h", a, q, e));
  endtask

  // ----------------------------------------
  // Pad expectation
  // ----------------------------------------
  // Result is {check value, oe, value}; tri-state value is left unchecked
  function automatic logic [2:0] drv(input logic [3:0] n, input logic f, input logic r);
    if (n[2])
      return {2'b11, r};
    case (n[1:0])
      2'h0:    return {2'b11, f};
      2'h1:    return {2'b11, n[3]};
      default: return 3'h0;
    endcase
  endfunction

  task automatic check_pads();
    logic [2:0] e [6];
    logic       s;
    s    = PORT_SEL | psel;
    e[0] = s ? 3'b100 : drv(c3[3:0], func_pat[0], link_pat[0]);
    e[1] = s ? drv(c3[3:0], func_pat[1], link_pat[1]) : 3'b100;
    e[2] = drv(c56[3:0], func_pat[2], link_pat[2]);
    e[3] = drv(c56[7:4], func_pat[3], link_pat[3]);
    e[4] = drv(c78[3:0], func_pat[4], link_pat[4]);
    e[5] = drv(c78[7:4], func_pat[5], link_pat[5]);
    for (int i = 0; i < 6; i++)
    begin
      cmp_count++;
      if (PAD_OE[i] !== e[i][1] || (e[i][2] && PAD_OUT[i] !== e[i][0]))
        fail($sformatf("pad %0d oe %b out %b want %b", i, PAD_OE[i], PAD_OUT[i], e[i]));
    end
  endtask

  // Pads follow a completed write one edge later
  task automatic settle();
    @(posedge CLK);
    #1;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge CLK);
    SRST <= 1'b0;
    @(posedge CLK);
    #1;
    // Reset config is functional output on routed pads
    check_pads();
    rd(8'h7c, 8'h00);
    rd(8'h80, 8'h00);
    rd(8'h84, 8'h00);
    rd(8'h94, 8'h00);
    $display("TEST reset done");
    for (int i = 0; i < 16; i++)
    begin
      func_pat <= i[0] ? 6'h15 : 6'h2a;
      link_pat <= i[0] ? 6'h2a : 6'h15;
      c56 = {i[3:0], ~i[3:0]};
      c78 = {~i[3:0], i[3:0]};
      wr(8'h80, c56, 4'h1);
      wr(8'h84, c78, 4'h1);
      settle();
      check_pads();
      rd(8'h80, c56);
    end
    // Link changes reach pins 6 and 7, whose remote bit is still set
    link_pat <= ~link_pat;
    settle();
    settle();
    check_pads();
    $display("TEST modes done");
    c3 = 8'hf9;
    wr(8'h7c, c3, 4'h1);
    settle();
    check_pads();
    rd(8'h7c, 8'hf9);
    PORT_SEL <= 1'b1;
    settle();
    settle();
    check_pads();
    // Strap released on a rising edge
    @(posedge CLK);
    PORT_SEL <= 1'b0;
    psel = 1'b1;
    wr(8'h94, 8'h01, 4'h1);
    settle();
    check_pads();
    c3 = 8'h04;
    wr(8'h7c, c3, 4'h1);
    settle();
    check_pads();
    $display("TEST port select done");
    wr(8'h40, 8'hff, 4'h1);
    rd(8'h40, 8'h00);
    wr(8'h80, 8'h5a, 4'h0);
    rd(8'h80, c56);
    c3  = 8'h02;
    c56 = 8'h22;
    c78 = 8'h22;
    wr(8'h7c, c3, 4'h1);
    wr(8'h80, c56, 4'h1);
    wr(8'h84, c78, 4'h1);
    ext_pat <= 6'h2d;
    settle();
    check_pads();
    repeat (2) @(posedge CLK);
    // Tri-state pads show the external level
    rd(8'h90, 8'h2d);
    wr(8'h90, 8'hff, 4'h1);
    rd(8'h90, 8'h2d);
    $display("TEST refusals done");
    // Mid-run reset must clear every field again
    @(posedge CLK);
    SRST <= 1'b1;
    repeat (2) @(posedge CLK);
    SRST <= 1'b0;
    c3   = 8'h00;
    c56  = 8'h00;
    c78  = 8'h00;
    psel = 1'b0;
    @(posedge CLK);
    #1;
    check_pads();
    rd(8'h7c, 8'h00);
    rd(8'h84, 8'h00);
    rd(8'h94, 8'h00);
    $display("TEST second reset done");
    tally_and_finish();
  end
endmodule
